// >>> rtl/mat_pkg.sv
// Types, constants and helpers of the station table engine
package mat_pkg;
    localparam int NBKT = 4;
    localparam int NPORTS = 11;
    localparam int V4_PORT_LSB = 24;
    localparam int V6_PORT_LSB = 32;
    localparam logic [9:0] LAST_ROW = 10'h3ff;
    localparam logic [1:0] ET_NORMAL = 2'h0;
    localparam logic [1:0] ET_LOCKED = 2'h1;
    localparam logic [1:0] ET_IPV4MC = 2'h2;
    localparam logic [1:0] ET_IPV6MC = 2'h3;
    localparam logic [23:0] V4_PREFIX = 24'h01005e;
    localparam logic [15:0] V6_PREFIX = 16'h3333;

    typedef enum logic [2:0] {
        CMD_IDLE = 3'h0, CMD_INSERT = 3'h1, CMD_REMOVE = 3'h2,
        CMD_AGE = 3'h3, CMD_NEXT = 3'h4, CMD_INIT = 3'h5,
        CMD_READ = 3'h6, CMD_WRITE = 3'h7
    } mat_cmd_e;

    typedef enum logic [2:0] {S_IDLE, S_EXEC, S_AGE, S_INIT, S_NEXT} mat_st_e;

    typedef struct packed {
        logic valid;
        logic [5:0] port_group_pointer;
        logic [1:0] etype;
        logic aged;
        logic cpu_copy;
        logic src_kill;
        logic ign_vlan;
    } mat_access_s;

    typedef struct packed {
        logic [12:0] vid;
        logic [47:0] mac;
        mat_access_s acc;
    } mat_entry_s;

    typedef struct packed {
        logic [9:0] row;
        logic [1:0] column_select;
    } mat_index_s;

    typedef struct packed {
        logic [47:0] mac;
        logic [12:0] vid;
        logic ipv4;
        logic ipv6;
    } mat_frame_s;

    typedef struct packed {
        logic hit;
        logic mc;
        logic [10:0] ports;
        logic [5:0] port_group_pointer;
    } mat_dst_s;

    typedef struct packed {
        mat_st_e st;
        mat_cmd_e field;
        mat_entry_s op;
        logic [1:0] col;
        logic [9:0] row;
        mat_entry_s res;
        logic [31:0] age_cnt;
        logic pend;
        mat_dst_s dst;
    } mat_state_s;

    localparam mat_state_s STATE_RST = '0;

    // Fold of the 61-bit key into a 10-bit row number
    function automatic logic [9:0] mat_hash(input logic [47:0] m,
                                            input logic [12:0] v);
        logic [69:0] k;
        logic [9:0] h;
        k = {9'h0, v, m};
        h = '0;
        for (int i = 0; i < 7; i++) h = h ^ k[i*10 +: 10];
        return h;
    endfunction

    // Multicast entries hash on their address part only, not port bits
    function automatic logic [47:0] mat_norm(input logic [47:0] m,
                                             input logic [1:0] et);
        if (et == ET_IPV4MC) return {24'h0, m[23:0]};
        if (et == ET_IPV6MC) return {16'h0, m[31:0]};
        return m;
    endfunction

    function automatic logic [59:0] mat_key60(input mat_entry_s e);
        return {e.vid[11:0], e.mac};
    endfunction
endpackage

// >>> rtl/mat_engine.sv
// Station table: age scans, software commands and multicast lookup
module mat_engine import mat_pkg::*; (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic cmd_wr,
    input wire mat_cmd_e cmd_code,
    input wire mat_access_s table_access_reg,
    input wire logic [31:0] key_low_data_reg,
    input wire logic [28:0] key_high_data_reg,
    input wire mat_index_s direct_index_reg,
    input wire logic [31:0] periodic_aging_cfg,
    input wire logic src_valid,
    input wire mat_frame_s src_frame,
    input wire logic dst_valid,
    input wire mat_frame_s dst_frame,
    output mat_cmd_e table_command_field,
    output mat_access_s result_access,
    output logic [31:0] result_low_data,
    output logic [28:0] result_high_data,
    output mat_dst_s dst_result
);
    mat_state_s r, nx;
    mat_entry_s tbl [0:4095];
    mat_entry_s rd [NBKT];
    mat_entry_s drd [NBKT];
    mat_entry_s srd [NBKT];
    mat_entry_s wr [NBKT];
    logic [3:0] we;
    logic [9:0] drow, srow, hrow;
    logic [47:0] dkey;
    logic v4, v6, done, mhit, fhit, tch_we;
    logic [1:0] mb, fb;
    logic [11:0] tch_idx;
    mat_entry_s tch_e, kin;

    for (genvar b = 0; b < NBKT; b++) begin : g_bkt
        assign rd[b] = tbl[{r.row, 2'(b)}];
        assign drd[b] = tbl[{drow, 2'(b)}];
        assign srd[b] = tbl[{srow, 2'(b)}];
    end

    assign kin = '{vid: key_high_data_reg[28:16],
                   mac: {key_high_data_reg[15:0], key_low_data_reg},
                   acc: table_access_reg};
    assign hrow = mat_hash(mat_norm(kin.mac, kin.acc.etype), kin.vid);

    // Learning touch; yields to a table write on the same row
    assign srow = mat_hash(src_frame.mac, src_frame.vid);
    always_comb begin
        tch_we = 1'b0;
        tch_idx = {srow, 2'h0};
        tch_e = srd[0];
        for (int b = NBKT - 1; b >= 0; b--) begin
            if (src_valid && srd[b].acc.valid && !srd[b].acc.etype[1] &&
                srd[b].vid == src_frame.vid &&
                srd[b].mac == src_frame.mac) begin
                tch_we = 1'b1;
                tch_idx = {srow, 2'(b)};
                tch_e = srd[b];
                tch_e.acc.aged = 1'b0;
            end
        end
        if (we != 4'h0 && srow == r.row) tch_we = 1'b0;
    end
    always_comb begin
        v4 = dst_frame.ipv4 && dst_frame.mac[47:24] == V4_PREFIX;
        v6 = dst_frame.ipv6 && dst_frame.mac[47:32] == V6_PREFIX;
        if (v4) dkey = {24'h0, dst_frame.mac[23:0]};
        else if (v6) dkey = {16'h0, dst_frame.mac[31:0]};
        else dkey = dst_frame.mac;
    end
    assign drow = mat_hash(dkey, dst_frame.vid);
    // Key match and free slot in the current row, lowest column_select first
    always_comb begin
        mhit = 1'b0;
        fhit = 1'b0;
        mb = 2'h0;
        fb = 2'h0;
        for (int b = NBKT - 1; b >= 0; b--) begin
            if (rd[b].acc.valid && rd[b].vid == r.op.vid &&
                rd[b].mac == r.op.mac) begin
                mhit = 1'b1;
                mb = 2'(b);
            end
            if (!rd[b].acc.valid) begin
                fhit = 1'b1;
                fb = 2'(b);
            end
        end
    end

    always_comb begin
        nx = r;
        we = 4'h0;
        wr = rd;
        done = 1'b0;
        nx.dst = '0;
        for (int b = NBKT - 1; b >= 0; b--) begin
            if (dst_valid && drd[b].acc.valid &&
                drd[b].vid == dst_frame.vid) begin
                case (drd[b].acc.etype)
                    ET_IPV4MC: begin
                        if (v4 && drd[b].mac[23:0] == dkey[23:0])
                            nx.dst = '{1'b1, 1'b1,
                                drd[b].mac[V4_PORT_LSB +: NPORTS], 6'h0};
                    end
                    ET_IPV6MC: begin
                        if (v6 && drd[b].mac[31:0] == dkey[31:0])
                            nx.dst = '{1'b1, 1'b1,
                                drd[b].mac[V6_PORT_LSB +: NPORTS], 6'h0};
                    end
                    default: begin
                        if (drd[b].mac == dst_frame.mac)
                            nx.dst = '{1'b1, 1'b0, 11'h0,
                                drd[b].acc.port_group_pointer};
                    end
                endcase
            end
        end
        case (r.st)
            S_IDLE: begin
                if (cmd_wr && cmd_code != CMD_IDLE) begin
                    nx.field = cmd_code;
                    nx.op = kin;
                    nx.col = direct_index_reg.column_select;
                    nx.row = '0;
                    case (cmd_code)
                        CMD_AGE: nx.st = S_AGE;
                        CMD_INIT: nx.st = S_INIT;
                        CMD_NEXT: begin
                            nx.st = S_NEXT;
                            nx.res.acc.valid = 1'b0;
                        end
                        CMD_WRITE: begin
                            nx.st = S_EXEC;
                            nx.row = direct_index_reg.row;
                        end
                        CMD_READ: begin
                            nx.st = S_EXEC;
                            nx.row = kin.acc.valid ? hrow
                                                   : direct_index_reg.row;
                        end
                        default: begin
                            nx.st = S_EXEC;
                            nx.row = hrow;
                        end
                    endcase
                end else if (r.pend) begin
                    nx.pend = 1'b0;
                    nx.field = CMD_AGE;
                    nx.st = S_AGE;
                    nx.row = '0;
                end
            end
            S_EXEC: begin
                done = 1'b1;
                case (r.field)
                    CMD_INSERT: begin
                        // A full row without a match drops the insert
                        if (mhit || fhit) begin
                            we[mhit ? mb : fb] = 1'b1;
                            wr[mhit ? mb : fb] = r.op;
                            wr[mhit ? mb : fb].acc.valid = 1'b1;
                        end
                    end
                    CMD_REMOVE: begin
                        if (mhit) begin
                            we[mb] = 1'b1;
                            wr[mb] = '0;
                        end
                    end
                    CMD_READ: begin
                        if (r.op.acc.valid) begin
                            nx.res = mhit ? rd[mb] : r.op;
                            nx.res.acc.valid = mhit;
                        end else begin
                            nx.res = rd[r.col];
                        end
                    end
                    CMD_WRITE: begin
                        we[r.col] = 1'b1;
                        wr[r.col] = r.op;
                    end
                    default: ;
                endcase
            end
            S_AGE: begin
                for (int b = 0; b < NBKT; b++) begin
                    if (rd[b].acc.valid) begin
                        we[b] = 1'b1;
                        // Locked and multicast types only get marked
                        if (rd[b].acc.aged && rd[b].acc.etype == ET_NORMAL)
                            wr[b] = '0;
                        else
                            wr[b].acc.aged = 1'b1;
                    end
                end
            end
            S_INIT: begin
                we = 4'hf;
                for (int b = 0; b < NBKT; b++) wr[b] = '0;
            end
            S_NEXT: begin
                for (int b = 0; b < NBKT; b++) begin
                    if (rd[b].acc.valid &&
                        mat_key60(rd[b]) > mat_key60(r.op) &&
                        (!nx.res.acc.valid ||
                         mat_key60(rd[b]) < mat_key60(nx.res)))
                        nx.res = rd[b];
                end
            end
            default: nx.st = S_IDLE;
        endcase
        // Row wraps to zero after the last one; unused once idle
        if (r.st inside {S_AGE, S_INIT, S_NEXT}) nx.row = r.row + 10'h1;
        if (r.st inside {S_AGE, S_INIT, S_NEXT} && r.row == LAST_ROW)
            done = 1'b1;
        if (done) begin
            nx.st = S_IDLE;
            nx.field = CMD_IDLE;
        end
        // Due scan waits while a command runs; a new due wins over clear
        if (periodic_aging_cfg != 32'h0 &&
            r.age_cnt >= periodic_aging_cfg - 32'h1) begin
            nx.age_cnt = '0;
            nx.pend = 1'b1;
        end else begin
            nx.age_cnt = r.age_cnt + 32'h1;
        end
    end
    always_ff @(posedge clk) begin
        if (sys_rst) r <= STATE_RST;
        else r <= nx;
    end
    // Table contents are undefined until an init command
    always_ff @(posedge clk) begin
        for (int b = 0; b < NBKT; b++) begin
            if (we[b]) tbl[{r.row, 2'(b)}] <= wr[b];
        end
        if (tch_we) tbl[tch_idx] <= tch_e;
    end
    assign table_command_field = r.field;
    assign result_access = r.res.acc;
    assign result_low_data = r.res.mac[31:0];
    assign result_high_data = {r.res.vid, r.res.mac[47:32]};
    assign dst_result = r.dst;
    property p_accept;
        @(posedge clk) disable iff (sys_rst)
        r.st == S_IDLE && cmd_wr && cmd_code != CMD_IDLE
        |=> table_command_field == $past(cmd_code);
    endproperty
    a_accept: assert property (p_accept) else $error("not taken");
    property p_hold;
        @(posedge clk) disable iff (sys_rst)
        table_command_field != CMD_IDLE && !done
        |=> $stable(table_command_field);
    endproperty
    a_hold: assert property (p_hold) else $error("field moved");
    property p_age_run;
        @(posedge clk) disable iff (sys_rst)
        r.st == S_IDLE && cmd_wr && cmd_code == CMD_AGE
        |=> (r.st == S_AGE && r.row != LAST_ROW)[*8];
    endproperty
    a_age_run: assert property (p_age_run) else $error("no scan");
    property p_auto;
        @(posedge clk) disable iff (sys_rst)
        r.st == S_IDLE && !cmd_wr && r.pend
        |=> r.st == S_AGE && table_command_field == CMD_AGE && r.row == 0;
    endproperty
    a_auto: assert property (p_auto) else $error("no auto scan");
    property p_age_del;
        @(posedge clk) disable iff (sys_rst)
        r.st == S_AGE && rd[0].acc.valid && rd[0].acc.aged &&
        rd[0].acc.etype == ET_NORMAL
        |=> !tbl[{$past(r.row), 2'h0}].acc.valid;
    endproperty
    a_age_del: assert property (p_age_del) else $error("kept");
    property p_age_mark;
        @(posedge clk) disable iff (sys_rst)
        r.st == S_AGE && rd[0].acc.valid && !rd[0].acc.aged
        |=> tbl[{$past(r.row), 2'h0}].acc.aged &&
            tbl[{$past(r.row), 2'h0}].acc.valid;
    endproperty
    a_age_mark: assert property (p_age_mark) else $error("unmarked");
    property p_touch;
        @(posedge clk) disable iff (sys_rst)
        tch_we |=> !tbl[$past(tch_idx)].acc.aged;
    endproperty
    a_touch: assert property (p_touch) else $error("still aged");
    property p_v4;
        @(posedge clk) disable iff (sys_rst)
        dst_valid && v4 && drd[0].acc.valid &&
        drd[0].acc.etype == ET_IPV4MC && drd[0].vid == dst_frame.vid &&
        drd[0].mac[23:0] == dst_frame.mac[23:0]
        |=> dst_result.hit && dst_result.mc &&
            dst_result.ports == $past(drd[0].mac[34:24]);
    endproperty
    a_v4: assert property (p_v4) else $error("bad v4 ports");
    property p_v6;
        @(posedge clk) disable iff (sys_rst)
        dst_valid && v6 && drd[0].acc.valid &&
        drd[0].acc.etype == ET_IPV6MC && drd[0].vid == dst_frame.vid &&
        drd[0].mac[31:0] == dst_frame.mac[31:0]
        |=> dst_result.hit && dst_result.mc &&
            dst_result.ports == $past(drd[0].mac[42:32]);
    endproperty
    a_v6: assert property (p_v6) else $error("bad v6 ports");
    property p_scan_end;
        @(posedge clk) disable iff (sys_rst)
        (r.st == S_INIT || r.st == S_AGE) && r.row == LAST_ROW
        |=> table_command_field == CMD_IDLE && r.st == S_IDLE;
    endproperty
    a_scan_end: assert property (p_scan_end) else $error("busy");
endmodule

// >>> dv/test_mac_table_age_and_command_engine.sv
// Self-checking testbench of the station table engine
`define CHK(what, exp, got) begin \
    compares++; \
    if ((got) !== (exp)) begin \
        err_count++; \
        $display("unexpected %s exp %h got %h", what, (exp), (got)); \
    end \
end

module test_mac_table_age_and_command_engine import mat_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic d; logic [73:0] v; logic [73:0] m;} mat_note_s;
    localparam logic [73:0] VMASK = {1'b1, 73'h0};
    logic clk = 0;
    logic sys_rst = 1;
    logic cmd_wr = 0;
    mat_cmd_e cmd_code = CMD_IDLE;
    mat_access_s table_access_reg = '0;
    logic [31:0] key_low_data_reg = '0;
    logic [28:0] key_high_data_reg = '0;
    mat_index_s direct_index_reg = '0;
    logic [31:0] periodic_aging_cfg = '0;
    logic src_valid = 0;
    mat_frame_s src_frame = '0;
    logic dst_valid = 0;
    mat_frame_s dst_frame = '0;
    mat_cmd_e table_command_field;
    mat_access_s result_access;
    logic [31:0] result_low_data;
    logic [28:0] result_high_data;
    mat_dst_s dst_result;
    int err_count = 0;
    int compares = 0;
    int seed = 32'h6418b123;
    mat_note_s notes[$];
    mat_note_s n;
    mat_cmd_e prev_field = CMD_IDLE;
    logic dv_q = 0;
    logic [47:0] ma, mb, mc, m0;
    logic [12:0] va, vb;
    mat_access_s aa, ab, ac;
    logic [59:0] key [4];

    always #5 clk = ~clk;

    mat_engine i_dut (
        .clk(clk), .sys_rst(sys_rst), .cmd_wr(cmd_wr), .cmd_code(cmd_code),
        .table_access_reg(table_access_reg),
        .key_low_data_reg(key_low_data_reg),
        .key_high_data_reg(key_high_data_reg),
        .direct_index_reg(direct_index_reg),
        .periodic_aging_cfg(periodic_aging_cfg),
        .src_valid(src_valid), .src_frame(src_frame),
        .dst_valid(dst_valid), .dst_frame(dst_frame),
        .table_command_field(table_command_field),
        .result_access(result_access), .result_low_data(result_low_data),
        .result_high_data(result_high_data), .dst_result(dst_result)
    );

    always @(posedge clk) dv_q <= dst_valid;

    // Results are judged one cycle after a lookup or when a read or next command returns to idle
    always @(negedge clk) begin
        if (dv_q || (table_command_field == CMD_IDLE &&
            (prev_field == CMD_READ || prev_field == CMD_NEXT))) begin
            if (notes.size() == 0) begin
                `CHK("note queue", 1'b1, 1'b0)
            end else begin
                n = notes.pop_front();
                if (n.d) `CHK("dst_result", n.v & n.m, {55'h0, dst_result} & n.m)
                else `CHK("result", n.v & n.m, {result_access,
                    result_low_data, result_high_data} & n.m)
            end
        end
        prev_field = table_command_field;
    end

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    function automatic logic [47:0] rnd48();
        return 48'({$random(seed), $random(seed)});
    endfunction

    function automatic mat_access_s mk(logic v, logic [5:0] p,
                                       logic [1:0] et, logic ag);
        return mat_access_s'({v, p, et, ag, 3'b101});
    endfunction

    // Own fold of the key, kept apart from the design's helper
    function automatic logic [9:0] row_of(logic [47:0] m, logic [12:0] v);
        logic [69:0] k;
        k = {9'h0, v, m};
        return k[9:0] ^ k[19:10] ^ k[29:20] ^ k[39:30] ^ k[49:40] ^
            k[59:50] ^ k[69:60];
    endfunction

    task automatic expect_res(mat_access_s a, logic [47:0] m,
                              logic [12:0] v, logic [73:0] msk);
        notes.push_back('{1'b0, {a, m[31:0], v, m[47:32]}, msk});
    endtask

    task automatic send(mat_cmd_e c, mat_access_s a, logic [47:0] m,
                        logic [12:0] v, logic [11:0] ix);
        @(negedge clk);
        cmd_wr = 1;
        cmd_code = c;
        table_access_reg = a;
        key_low_data_reg = m[31:0];
        key_high_data_reg = {v, m[47:32]};
        direct_index_reg = ix;
        @(negedge clk);
        cmd_wr = 0;
    endtask

    task automatic idle_wait();
        for (int i = 0; i < 3000 && table_command_field != CMD_IDLE; i++)
            @(negedge clk);
        `CHK("idle", CMD_IDLE, table_command_field)
    endtask

    task automatic run(mat_cmd_e c, mat_access_s a, logic [47:0] m,
                       logic [12:0] v, logic [11:0] ix);
        int k;
        int lat;
        lat = (c == CMD_AGE || c == CMD_INIT || c == CMD_NEXT) ? 1025 : 2;
        send(c, a, m, v, ix);
        `CHK("busy code", c, table_command_field)
        k = 1;
        while (table_command_field != CMD_IDLE && k < 3000) begin
            @(negedge clk);
            k++;
        end
        `CHK("latency", lat, k)
    endtask

    task automatic find(logic [47:0] m, logic [12:0] v, logic [1:0] et,
                        mat_access_s a);
        expect_res(a, m, v, a.valid ? {74{1'b1}} : VMASK);
        run(CMD_READ, mat_access_s'({1'b1, 6'h0, et, 4'h0}), m, v, '0);
    endtask

    task automatic lookup(logic [47:0] m, logic [12:0] v, logic [1:0] fam,
                          logic [18:0] exp, logic [18:0] msk);
        notes.push_back('{1'b1, {55'h0, exp}, {55'h0, msk}});
        @(negedge clk);
        dst_valid = 1;
        dst_frame = mat_frame_s'({m, v, fam});
        @(negedge clk);
        dst_valid = 0;
        @(negedge clk);
    endtask

    initial begin
        repeat (40000) @(posedge clk);
        err_count++;
        $display("watchdog expired");
        stop_test();
    end

    initial begin
        repeat (12) @(posedge clk);
        @(negedge clk);
        sys_rst = 0;
        @(negedge clk);
        `CHK("reset field", CMD_IDLE, table_command_field)
        run(CMD_INIT, '0, '0, '0, '0);
        // Edge rows, every column and every entry type
        for (int i = 0; i < 4; i++) begin
            m0 = rnd48();
            aa = mk(1'b1, 6'($random(seed)), 2'(i), 1'b0);
            va = 13'($random(seed));
            key[0][11:0] = {(i == 0) ? 10'h0 : (i == 1) ? LAST_ROW :
                10'($random(seed)), 2'(i)};
            run(CMD_WRITE, aa, m0, va, key[0][11:0]);
            expect_res(aa, m0, va, '1);
            run(CMD_READ, '0, '0, '0, key[0][11:0]);
        end
        $display("test direct done");
        run(CMD_INIT, '0, '0, '0, '0);
        ma = rnd48();
        va = 13'($random(seed)) & 13'h0fff;
        aa = mk(1'b1, 6'h2a, ET_NORMAL, 1'b0);
        run(CMD_INSERT, aa, ma, va, '0);
        find(ma, va, ET_NORMAL, aa);
        expect_res(aa, ma, va, '1);
        run(CMD_READ, '0, '0, '0, {row_of(ma, va), 2'h0});
        run(CMD_REMOVE, '0, ma, va, '0);
        find(ma, va, ET_NORMAL, '0);
        $display("test keyed done");
        ab = mk(1'b1, 6'h28, ET_LOCKED, 1'b0);
        mb = 48'h010000112233;
        vb = 13'd12;
        ac = mk(1'b1, 6'h0, ET_IPV4MC, 1'b0);
        mc = 48'h000308112233;
        run(CMD_INSERT, aa, ma, va, '0);
        run(CMD_INSERT, ab, mb, vb, '0);
        run(CMD_INSERT, ac, mc, vb, '0);
        run(CMD_AGE, '0, '0, '0, '0);
        aa.aged = 1;
        ab.aged = 1;
        ac.aged = 1;
        find(ma, va, ET_NORMAL, aa);
        @(negedge clk);
        src_valid = 1;
        src_frame = mat_frame_s'({ma, va, 2'b00});
        @(negedge clk);
        src_valid = 0;
        run(CMD_AGE, '0, '0, '0, '0);
        find(ma, va, ET_NORMAL, aa);
        send(CMD_AGE, '0, '0, '0, '0);
        // Dropped while the scan runs
        send(CMD_WRITE, aa, rnd48(), va, {10'h7, 2'h3});
        idle_wait();
        find(ma, va, ET_NORMAL, '0);
        find(mb, vb, ET_LOCKED, ab);
        find(mc, vb, ET_IPV4MC, ac);
        expect_res('0, '0, '0, VMASK);
        run(CMD_READ, '0, '0, '0, {10'h7, 2'h3});
        $display("test aging done");
        aa = mk(1'b1, 6'h0, ET_IPV6MC, 1'b0);
        run(CMD_INSERT, aa, 48'h030800112233, vb, '0);
        lookup(48'h01005e112233, vb, 2'b10, {2'b11, 11'h308, 6'h0},
            {13'h1fff, 6'h0});
        lookup(48'h01005e112233, vb, 2'b01, '0, {1'b1, 18'h0});
        lookup(48'h01005e112233, 13'd13, 2'b10, '0, {1'b1, 18'h0});
        lookup(48'h333300112233, vb, 2'b01, {2'b11, 11'h308, 6'h0},
            {13'h1fff, 6'h0});
        lookup(48'h333300112233, vb, 2'b10, '0, {1'b1, 18'h0});
        lookup(mb, vb, 2'b00, {2'b10, 11'h0, 6'h28},
            {2'b11, 11'h0, 6'h3f});
        $display("test multicast done");
        run(CMD_INIT, '0, '0, '0, '0);
        m0 = rnd48() & 48'h7fffffffff00;
        key[0] = {12'd5, m0};
        key[1] = {12'd5, m0 + 48'd2};
        key[2] = {12'd5, m0 + 48'd7};
        key[3] = {12'd6, 48'h0};
        // Larger keys sit at lower rows
        for (int i = 1; i < 4; i++)
            run(CMD_WRITE, ab, key[i][47:0], {1'b0, key[i][59:48]},
                {10'(1000 - i * 300), 2'(i)});
        for (int i = 0; i < 4; i++) begin
            if (i < 3)
                expect_res(ab, key[i + 1][47:0], {1'b0, key[i + 1][59:48]},
                    '1);
            else
                expect_res('0, '0, '0, VMASK);
            run(CMD_NEXT, '0, key[i][47:0], {1'b0, key[i][59:48]}, '0);
        end
        $display("test successor done");
        ma = rnd48();
        run(CMD_INSERT, mk(1'b1, 6'h1, ET_NORMAL, 1'b0), ma, va, '0);
        @(negedge clk);
        periodic_aging_cfg = 32'd2000;
        repeat (5500) @(negedge clk);
        periodic_aging_cfg = '0;
        idle_wait();
        find(ma, va, ET_NORMAL, '0);
        $display("test periodic done");
        stop_test();
    end
endmodule
